// [src/ioh_core.sv]
// How it works
// - Command: address, instruction, type, bank, four value bytes MSB first, checksum.
// - Reply: host, target, status 64h on success, instruction, value, checksum.
// - Instruction 0B, bank 2 writes the chosen user variable to storage.
// - Instruction 12, bank 2 reloads the chosen user variable from storage.
// - User variables 0 to 15 are reloaded after reset before commands are taken.
// - Instruction 13 starts, stops or queries the homing search of motor 0.
// - Query returns 0 when idle, nonzero while active; start and stop return 0.
// - Instruction 14, bank 2 drives the chosen output to value 0 or 1.
// - Two outputs, ports 0 and 1.
// - Port 255 in bank 2 sets all outputs from the low value bits.
// - Port 255 value -1 takes the output vector from the accumulator.
// - Port 0, bank 0 switches both stop and home pull-ups together.
// - Instruction 15 reads the line chosen by port and bank 0, 1 or 2.
// - Digital lines read 0 or 1, converter channels read 0 to 4095.
// - From a stored program a read also loads the accumulator.
// - From the host a read only answers and leaves the accumulator alone, except port 255 in bank 0.
// - Bank 2 reads return the output levels last set.
// - Port 255, bank 0 loads all inputs into the low accumulator byte.
`default_nettype none
module ioh_core (
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic [7:0]  my_addr,
  input  wire logic [7:0]  host_addr,
  input  wire logic        prog_mode,
  input  wire logic        rx_valid,
  input  wire logic [7:0]  rx_byte,
  output logic             rx_ready,
  output logic             tx_valid,
  output logic [7:0]       tx_byte,
  input  wire logic        tx_ready,
  output logic             csum_err,
  output logic [7:0]       uv_addr,
  input  wire logic [31:0] uv_rdata,
  output logic             uv_we,
  output logic [31:0]      uv_wdata,
  output logic             nv_req,
  output logic             nv_we,
  output logic [7:0]       nv_addr,
  output logic [31:0]      nv_wdata,
  input  wire logic        nv_ack,
  input  wire logic [31:0] nv_rdata,
  output logic             hs_start,
  output logic             hs_stop,
  input  wire logic        hs_active,
  input  wire logic [7:0]  din,
  output logic [7:0]       adc_chan,
  input  wire logic [11:0] adc_value,
  output logic             gp_output_0,
  output logic             gp_output_1,
  output logic             pullup_en,
  output logic [31:0]      acc
);

  ioh_pkg::ioh_regs_s s_q;
  ioh_pkg::ioh_regs_s s_d;
  logic [7:0]  ins;
  logic [7:0]  typ;
  logic [7:0]  bnk;
  logic [31:0] val;
  logic        is_ex;

  // Decoded fields of the held command
  assign ins   = s_q.cmd[55:48];
  assign typ   = s_q.cmd[47:40];
  assign bnk   = s_q.cmd[39:32];
  assign val   = s_q.cmd[31:0];
  assign is_ex = (s_q.st == ioh_pkg::S_EXEC);

  ////////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb
  begin
    logic [7:0]  status;
    logic [31:0] rval;
    logic        rd;
    status = ioh_pkg::ST_OK;
    rval   = 32'h0000_0000;
    rd     = 1'b0;
    s_d = s_q;
    s_d.din1    = din;
    s_d.din2    = s_q.din1;
    s_d.hs_go   = 1'b0;
    s_d.hs_halt = 1'b0;
    s_d.uv_we   = 1'b0;
    s_d.cs_err  = 1'b0;
    unique case (s_q.st)
      ioh_pkg::S_INIT:
      begin
        // Power-up reload of one variable; the index steps on only after its write pulse
        if (s_q.uv_we)
          s_d.idx = s_q.idx + 8'h01;
        s_d.nv_req = 1'b1;
        s_d.nv_we  = 1'b0;
        s_d.rst_op = 1'b1;
        s_d.init   = 1'b1;
        s_d.st     = ioh_pkg::S_NV;
      end
      ioh_pkg::S_RX:
      begin
        if (rx_valid)
        begin
          if (s_q.cnt != ioh_pkg::LAST_IDX)
          begin
            s_d.cmd = {s_q.cmd[55:0], rx_byte};
            s_d.sum = s_q.sum + rx_byte;
            s_d.cnt = s_q.cnt + 4'h1;
          end
          else
          begin
            s_d.cnt = 4'h0;
            s_d.sum = 8'h00;
            s_d.cs_err = (rx_byte != s_q.sum);
            if (rx_byte == s_q.sum && s_q.cmd[63:56] == my_addr)
            begin
              s_d.st   = ioh_pkg::S_EXEC;
              s_d.prog = prog_mode;
              s_d.idx  = s_q.cmd[47:40];
            end
          end
        end
      end
      ioh_pkg::S_EXEC:
      begin
        s_d.st = ioh_pkg::S_TX;
        unique case (ins)
          ioh_pkg::INS_STORE, ioh_pkg::INS_RESTO:
          begin
            if (bnk == ioh_pkg::BANK_GP)
            begin
              s_d.nv_req   = 1'b1;
              s_d.nv_we    = (ins == ioh_pkg::INS_STORE);
              s_d.rst_op   = (ins == ioh_pkg::INS_RESTO);
              s_d.uv_wdata = uv_rdata;
              s_d.st       = ioh_pkg::S_NV;
            end
            else
              status = ioh_pkg::ST_BAD;
          end
          ioh_pkg::INS_HOME:
          begin
            if (bnk != ioh_pkg::MOTOR0 || typ > ioh_pkg::HS_QUERY)
              status = ioh_pkg::ST_BAD;
            s_d.hs_go   = (bnk == ioh_pkg::MOTOR0) && (typ == ioh_pkg::HS_START);
            s_d.hs_halt = (bnk == ioh_pkg::MOTOR0) && (typ == ioh_pkg::HS_STOP);
            if (typ == ioh_pkg::HS_QUERY)
              rval = {31'h0000_0000, hs_active};
          end
          ioh_pkg::INS_SETIO:
          begin
            if (bnk == ioh_pkg::BANK_GP && typ <= ioh_pkg::GP_LAST)
              s_d.gpo[typ[0]] = val[0];
            else if (bnk == ioh_pkg::BANK_GP && typ == ioh_pkg::PORT_ALL)
              s_d.gpo = (val == ioh_pkg::VAL_ACC) ? s_q.acc[1:0] : val[1:0];
            else if (bnk == ioh_pkg::BANK_IN && typ == ioh_pkg::PORT_PU)
              s_d.pu = val[0];
            else
              status = ioh_pkg::ST_BAD;
          end
          ioh_pkg::INS_GETIO:
          begin
            rd = 1'b1;
            // Line selected by port and bank
            if (bnk == ioh_pkg::BANK_IN && typ <= ioh_pkg::DIN_LAST)
              rval = {31'h0000_0000, s_q.din2[typ[2:0]]};
            else if (bnk == ioh_pkg::BANK_IN && typ == ioh_pkg::PORT_ALL)
              rval = {24'h00_0000, s_q.din2};
            else if (bnk == ioh_pkg::BANK_ADC)
              rval = {20'h0_0000, adc_value};
            else if (bnk == ioh_pkg::BANK_GP && typ <= ioh_pkg::GP_LAST)
              rval = {31'h0000_0000, s_q.gpo[typ[0]]};
            else
            begin
              status = ioh_pkg::ST_BAD;
              rd = 1'b0;
            end
            if (rd && (s_q.prog || (bnk == ioh_pkg::BANK_IN && typ == ioh_pkg::PORT_ALL)))
              s_d.acc = rval;
          end
          default:
            status = ioh_pkg::ST_BAD;
        endcase
        s_d.rep[71:8] = {host_addr, my_addr, status, ins, rval};
        s_d.rep[7:0]  = ioh_pkg::ioh_csum({host_addr, my_addr, status, ins, rval});
        s_d.cnt = 4'h0;
      end
      ioh_pkg::S_NV:
      begin
        if (nv_ack)
        begin
          s_d.nv_req = 1'b0;
          s_d.nv_we  = 1'b0;
          if (s_q.rst_op)
          begin
            s_d.uv_we    = 1'b1;
            s_d.uv_wdata = nv_rdata;
          end
          s_d.rst_op = 1'b0;
          if (!s_q.init)
            s_d.st = ioh_pkg::S_TX;
          else if (s_q.idx == ioh_pkg::NUM_VARS - 8'h01)
          begin
            // Index held so the last write pulse still lands on it
            s_d.init = 1'b0;
            s_d.st   = ioh_pkg::S_RX;
          end
          else
            s_d.st = ioh_pkg::S_INIT;
        end
      end
      ioh_pkg::S_TX:
      begin
        if (tx_ready)
        begin
          s_d.rep = {s_q.rep[63:0], 8'h00};
          s_d.cnt = s_q.cnt + 4'h1;
          if (s_q.cnt == ioh_pkg::LAST_IDX)
          begin
            s_d.cnt = 4'h0;
            s_d.st  = ioh_pkg::S_RX;
          end
        end
      end
      default:
        s_d.st = ioh_pkg::S_RX;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge clk)
  begin
    if (!rst_n)
      s_q <= '{st: ioh_pkg::S_INIT, default: '0};
    else
      s_q <= s_d;
  end

  // Outputs
  assign rx_ready    = (s_q.st == ioh_pkg::S_RX);
  assign tx_valid    = (s_q.st == ioh_pkg::S_TX);
  assign tx_byte     = s_q.rep[71:64];
  assign csum_err    = s_q.cs_err;
  assign uv_addr     = s_q.idx;
  assign uv_we       = s_q.uv_we;
  assign uv_wdata    = s_q.uv_wdata;
  assign nv_req      = s_q.nv_req;
  assign nv_we       = s_q.nv_we;
  assign nv_addr     = s_q.idx;
  assign nv_wdata    = s_q.uv_wdata;
  assign hs_start    = s_q.hs_go;
  assign hs_stop     = s_q.hs_halt;
  assign adc_chan    = typ;
  assign gp_output_0 = s_q.gpo[0];
  assign gp_output_1 = s_q.gpo[1];
  assign pullup_en   = s_q.pu;
  assign acc         = s_q.acc;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  reply_csum_a: assert property ($rose(tx_valid) |->
    s_q.rep[7:0] == ioh_pkg::ioh_csum(s_q.rep[71:8]))
    else $error("reply checksum wrong");
  bad_frame_a: assert property (rx_valid && rx_ready && s_q.cnt == ioh_pkg::LAST_IDX
    && rx_byte != s_q.sum |=> rx_ready && csum_err)
    else $error("bad checksum frame not dropped");
  init_first_a: assert property (rx_ready |-> !s_q.init)
    else $error("command taken before reload");
  set_one_a: assert property (is_ex && ins == ioh_pkg::INS_SETIO
    && bnk == ioh_pkg::BANK_GP && typ == 8'h00 |=> gp_output_0 == $past(val[0]))
    else $error("output 0 not set");
  set_acc_a: assert property (is_ex && ins == ioh_pkg::INS_SETIO
    && bnk == ioh_pkg::BANK_GP && typ == ioh_pkg::PORT_ALL && val == ioh_pkg::VAL_ACC
    |=> {gp_output_1, gp_output_0} == $past(acc[1:0]))
    else $error("outputs not taken from accumulator");
  pullup_a: assert property (is_ex && ins == ioh_pkg::INS_SETIO
    && bnk == ioh_pkg::BANK_IN && typ == ioh_pkg::PORT_PU |=> pullup_en == $past(val[0]))
    else $error("pull-up not switched");
  direct_read_a: assert property (is_ex && ins == ioh_pkg::INS_GETIO && !s_q.prog
    && !(bnk == ioh_pkg::BANK_IN && typ == ioh_pkg::PORT_ALL) |=> $stable(acc))
    else $error("direct read changed accumulator");
  home_start_a: assert property (is_ex && ins == ioh_pkg::INS_HOME
    && bnk == ioh_pkg::MOTOR0 && typ == ioh_pkg::HS_START |=> hs_start ##1 !hs_start)
    else $error("homing start not pulsed");
  restore_a: assert property (s_q.st == ioh_pkg::S_NV && nv_ack && s_q.rst_op
    |=> uv_we && uv_addr == $past(nv_addr) && uv_wdata == $past(nv_rdata))
    else $error("restored value not written");

  cover_read_c: cover property (is_ex && ins == ioh_pkg::INS_GETIO ##1 tx_valid);
  cover_init_c: cover property (s_q.init ##1 !s_q.init);
  cover_all_c: cover property (is_ex && ins == ioh_pkg::INS_SETIO && typ == ioh_pkg::PORT_ALL);

endmodule : ioh_core
`default_nettype wire

// [src/ioh_pkg.sv]
`default_nettype none
package ioh_pkg;
  // Frame layout
  localparam int         FRAME_LEN = 9;
  localparam logic [3:0] LAST_IDX  = 4'h8;
  localparam logic [7:0] ST_OK     = 8'h64;
  localparam logic [7:0] ST_BAD    = 8'h02;
  // Instruction numbers
  localparam logic [7:0] INS_STORE = 8'h0B;
  localparam logic [7:0] INS_RESTO = 8'h0C;
  localparam logic [7:0] INS_HOME  = 8'h0D;
  localparam logic [7:0] INS_SETIO = 8'h0E;
  localparam logic [7:0] INS_GETIO = 8'h0F;
  // Banks, ports and special values
  localparam logic [7:0]  BANK_IN   = 8'h00;
  localparam logic [7:0]  BANK_ADC  = 8'h01;
  localparam logic [7:0]  BANK_GP   = 8'h02;
  localparam logic [7:0]  MOTOR0    = 8'h00;
  localparam logic [7:0]  PORT_ALL  = 8'hFF;
  localparam logic [7:0]  PORT_PU   = 8'h00;
  localparam logic [7:0]  DIN_LAST  = 8'h07;
  localparam logic [7:0]  GP_LAST   = 8'h01;
  localparam logic [31:0] VAL_ACC   = 32'hFFFF_FFFF;
  localparam logic [7:0]  HS_START  = 8'h00;
  localparam logic [7:0]  HS_STOP   = 8'h01;
  localparam logic [7:0]  HS_QUERY  = 8'h02;
  // Number of user variables reloaded at power up
  localparam logic [7:0]  NUM_VARS  = 8'h10;

  typedef enum logic [2:0] {
    S_RX   = 3'b000,
    S_EXEC = 3'b001,
    S_NV   = 3'b011,
    S_TX   = 3'b010,
    S_INIT = 3'b110
  } ioh_state_e;

  typedef struct packed {
    ioh_state_e  st;
    logic [3:0]  cnt;
    logic [63:0] cmd;
    logic [7:0]  sum;
    logic [71:0] rep;
    logic [31:0] acc;
    logic [1:0]  gpo;
    logic        pu;
    logic        hs_go;
    logic        hs_halt;
    logic        nv_req;
    logic        nv_we;
    logic        rst_op;
    logic        init;
    logic [7:0]  idx;
    logic        uv_we;
    logic [31:0] uv_wdata;
    logic        prog;
    logic        cs_err;
    logic [7:0]  din1;
    logic [7:0]  din2;
  } ioh_regs_s;

  // Modulo-256 sum of eight bytes
  function automatic logic [7:0] ioh_csum(input logic [63:0] b);
    logic [7:0] s;
    s = 8'h00;
    for (int i = 0; i < 8; i++)
      s = s + b[i*8 +: 8];
    return s;
  endfunction : ioh_csum
endpackage : ioh_pkg
`default_nettype wire

// [src/unused_placeholder_none.sv]
`default_nettype none
`default_nettype wire

// [testbench/ioh_far_model.sv]
`default_nettype none
module ioh_far_model (
  input  wire logic        clk,
  input  wire logic [7:0]  uv_addr,
  output logic [31:0]      uv_rdata,
  input  wire logic        uv_we,
  input  wire logic [31:0] uv_wdata,
  input  wire logic        nv_req,
  input  wire logic        nv_we,
  input  wire logic [7:0]  nv_addr,
  input  wire logic [31:0] nv_wdata,
  output logic             nv_ack,
  output logic [31:0]      nv_rdata,
  input  wire logic        hs_start,
  input  wire logic        hs_stop,
  output logic             hs_active
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] nv [256];
  logic [31:0] uv [256];
  int          dly = 0;
  int          wt = 0;
  // Storage preload and idle levels
  initial
  begin
    for (int i = 0; i < 256; i++)
    begin
      nv[i] = 32'h5A00_0000 + i;
      uv[i] = 32'h0000_0000;
    end
    nv_ack = 1'b0;
    nv_rdata = 32'h0000_0000;
    hs_active = 1'b0;
  end
  assign uv_rdata = uv[uv_addr];
  // Storage answers after dly cycles; read data only valid with ack
  always @(posedge clk)
  begin
    nv_ack <= 1'b0;
    nv_rdata <= ~nv_rdata;
    if (uv_we === 1'b1)
      uv[uv_addr] <= uv_wdata;
    if (nv_req === 1'b1 && nv_ack !== 1'b1)
    begin
      wt <= wt + 1;
      if (wt >= dly)
      begin
        wt <= 0;
        nv_ack <= 1'b1;
        nv_rdata <= nv[nv_addr];
        if (nv_we === 1'b1)
          nv[nv_addr] <= nv_wdata;
      end
    end
    // Homing engine runs from start pulse to stop pulse
    if (hs_start === 1'b1)
      hs_active <= 1'b1;
    if (hs_stop === 1'b1)
      hs_active <= 1'b0;
  end
endmodule : ioh_far_model
`default_nettype wire

// [testbench/tb_io_and_homing_command_handler.sv]
`default_nettype none
module tb_io_and_homing_command_handler;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] MYA  = 8'h01;
  localparam logic [7:0] HOST = 8'h02;
  logic        clk = 0, rst_n = 0, prog_mode = 0, rx_valid = 0, tx_ready = 1, slow = 0;
  logic [7:0]  rx_byte = 8'h00, din = 8'h00, tx_byte, uv_addr, nv_addr, adc_chan;
  logic        rx_ready, tx_valid, csum_err, uv_we, nv_req, nv_we, nv_ack;
  logic        hs_start, hs_stop, hs_active, gp_output_0, gp_output_1, pullup_en;
  logic [31:0] uv_rdata, uv_wdata, nv_wdata, nv_rdata, acc;
  logic [11:0] adc_value;
  int          err_count = 0, num_checks = 0, ce = 0, txc = 0, t0 = 0;
  logic [31:0] rv;
  assign adc_value = 12'hFFF - {4'h0, adc_chan};
  ioh_core dut (.clk(clk), .rst_n(rst_n), .my_addr(MYA), .host_addr(HOST),
    .prog_mode(prog_mode), .rx_valid(rx_valid), .rx_byte(rx_byte), .rx_ready(rx_ready),
    .tx_valid(tx_valid), .tx_byte(tx_byte), .tx_ready(tx_ready), .csum_err(csum_err),
    .uv_addr(uv_addr), .uv_rdata(uv_rdata), .uv_we(uv_we), .uv_wdata(uv_wdata),
    .nv_req(nv_req), .nv_we(nv_we), .nv_addr(nv_addr), .nv_wdata(nv_wdata),
    .nv_ack(nv_ack), .nv_rdata(nv_rdata), .hs_start(hs_start), .hs_stop(hs_stop),
    .hs_active(hs_active), .din(din), .adc_chan(adc_chan), .adc_value(adc_value),
    .gp_output_0(gp_output_0), .gp_output_1(gp_output_1), .pullup_en(pullup_en),
    .acc(acc));
  ioh_far_model far (.clk(clk), .uv_addr(uv_addr), .uv_rdata(uv_rdata), .uv_we(uv_we),
    .uv_wdata(uv_wdata), .nv_req(nv_req), .nv_we(nv_we), .nv_addr(nv_addr),
    .nv_wdata(nv_wdata), .nv_ack(nv_ack), .nv_rdata(nv_rdata), .hs_start(hs_start),
    .hs_stop(hs_stop), .hs_active(hs_active));
  // Clock
  initial
  begin
    forever #5 clk = ~clk;
  end
  // Count error pulses and reply cycles
  always @(posedge clk)
  begin
    if (csum_err === 1'b1)
      ce++;
    if (tx_valid === 1'b1)
      txc++;
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      err_count++;
      $display("Error %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check
  task automatic conclude();
    if (err_count == 0 && num_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : conclude
  // Send one frame, checksum offset by adj
  task automatic cmd(input logic [7:0] ad, ins, ty, bk, input logic [31:0] v,
                     input logic [7:0] adj);
    logic [71:0] f;
    f = {ad, ins, ty, bk, v, adj};
    for (int i = 1; i < 9; i++)
      f[7:0] = f[7:0] + f[i*8 +: 8];
    for (int i = 8; i >= 0; i--)
    begin
      rx_valid = 1'b1;
      rx_byte = f[i*8 +: 8];
      while (rx_ready !== 1'b1)
        @(negedge clk);
      @(negedge clk);
    end
    rx_valid = 1'b0;
  endtask : cmd
  // Collect one reply, optionally stalling
  task automatic rep(input logic [7:0] ins, st, output logic [31:0] v);
    logic [7:0] r [9];
    logic [7:0] s;
    s = 8'h00;
    for (int i = 0; i < 9; i++)
    begin
      if (slow)
      begin
        tx_ready = 1'b0;
        repeat (2) @(negedge clk);
        tx_ready = 1'b1;
      end
      while (tx_valid !== 1'b1)
        @(negedge clk);
      r[i] = tx_byte;
      if (i < 8)
        s = s + r[i];
      @(negedge clk);
    end
    check({r[0], r[1], r[2], r[3]}, {HOST, MYA, st, ins});
    check(32'(r[8]), 32'(s));
    v = {r[4], r[5], r[6], r[7]};
  endtask : rep
  task automatic op(input logic [7:0] ins, ty, bk, input logic [31:0] v, ex, input bit cv);
    logic [31:0] got;
    cmd(MYA, ins, ty, bk, v, 8'h00);
    rep(ins, ioh_pkg::ST_OK, got);
    if (cv)
      check(got, ex);
  endtask : op
  task automatic outs(input logic [2:0] ex);
    check(32'({pullup_en, gp_output_1, gp_output_0}), 32'(ex));
  endtask : outs
  ////////////////////////////////////////////////////////////////////////////////
  // Watchdog
  initial
  begin
    repeat (30000) @(posedge clk);
    err_count++;
    conclude();
  end
  // Test sequence
  initial
  begin
    repeat (20) @(negedge clk);
    for (int k = 0; k < 2; k++)
    begin
      rst_n = 1'b1;
      outs(3'b000);
      while (rx_ready !== 1'b1)
        @(negedge clk);
      // The last reload write lands one edge after commands open
      @(negedge clk);
      for (int i = 0; i < 17; i++)
      begin
        rv = (i < 16) ? 32'h5A00_0000 + i : 32'h0000_0000;
        if (k == 1 && i == 3)
          rv = 32'hCAFE_0003;
        check(far.uv[i], rv);
      end
      if (k == 1)
        break;
      far.uv[3] = 32'hCAFE_0003;
      op(ioh_pkg::INS_STORE, 8'h03, ioh_pkg::BANK_GP, 0, 0, 0);
      check(far.nv[3], 32'hCAFE_0003);
      // Store outside bank 2 is refused with the error status
      cmd(MYA, ioh_pkg::INS_STORE, 8'h03, ioh_pkg::BANK_IN, 0, 8'h00);
      rep(ioh_pkg::INS_STORE, ioh_pkg::ST_BAD, rv);
      check(rv, 32'h0000_0000);
      far.uv[3] = 32'h0000_0001;
      far.dly = 3;
      slow = 1;
      op(ioh_pkg::INS_RESTO, 8'h03, ioh_pkg::BANK_GP, 0, 0, 0);
      check(far.uv[3], 32'hCAFE_0003);
      slow = 0;
      op(ioh_pkg::INS_HOME, ioh_pkg::HS_START, ioh_pkg::MOTOR0, 0, 0, 1);
      op(ioh_pkg::INS_HOME, ioh_pkg::HS_QUERY, ioh_pkg::MOTOR0, 0, 1, 1);
      op(ioh_pkg::INS_HOME, ioh_pkg::HS_STOP, ioh_pkg::MOTOR0, 0, 0, 1);
      op(ioh_pkg::INS_HOME, ioh_pkg::HS_QUERY, ioh_pkg::MOTOR0, 0, 0, 1);
      op(ioh_pkg::INS_SETIO, 8'h00, ioh_pkg::BANK_GP, 1, 0, 0);
      outs(3'b001);
      op(ioh_pkg::INS_SETIO, 8'h01, ioh_pkg::BANK_GP, 1, 0, 0);
      op(ioh_pkg::INS_GETIO, 8'h01, ioh_pkg::BANK_GP, 0, 1, 1);
      op(ioh_pkg::INS_SETIO, ioh_pkg::PORT_ALL, ioh_pkg::BANK_GP, 2, 0, 0);
      outs(3'b010);
      op(ioh_pkg::INS_GETIO, 8'h00, ioh_pkg::BANK_GP, 0, 0, 1);
      op(ioh_pkg::INS_SETIO, ioh_pkg::PORT_PU, ioh_pkg::BANK_IN, 1, 0, 0);
      outs(3'b110);
      din = 8'hA5;
      op(ioh_pkg::INS_GETIO, ioh_pkg::PORT_ALL, ioh_pkg::BANK_IN, 0, 32'h0000_00A5, 1);
      check(acc, 32'h0000_00A5);
      op(ioh_pkg::INS_SETIO, ioh_pkg::PORT_ALL, ioh_pkg::BANK_GP, ioh_pkg::VAL_ACC, 0, 0);
      outs(3'b101);
      op(ioh_pkg::INS_GETIO, 8'h02, ioh_pkg::BANK_IN, 0, 1, 1);
      op(ioh_pkg::INS_GETIO, 8'h01, ioh_pkg::BANK_IN, 0, 0, 1);
      op(ioh_pkg::INS_GETIO, 8'h00, ioh_pkg::BANK_ADC, 0, 32'h0FFF, 1);
      check(acc, 32'h0000_00A5);
      prog_mode = 1'b1;
      op(ioh_pkg::INS_GETIO, 8'h07, ioh_pkg::BANK_ADC, 0, 32'h0FF8, 1);
      check(acc, 32'h0000_0FF8);
      prog_mode = 1'b0;
      t0 = txc;
      cmd(MYA, ioh_pkg::INS_GETIO, 8'h00, ioh_pkg::BANK_IN, 0, 8'h01);
      @(negedge clk);
      cmd(8'h07, ioh_pkg::INS_GETIO, 8'h00, ioh_pkg::BANK_IN, 0, 8'h00);
      repeat (20) @(negedge clk);
      check(32'(ce), 32'd1);
      check(32'(txc - t0), 32'd0);
      op(ioh_pkg::INS_SETIO, ioh_pkg::PORT_PU, ioh_pkg::BANK_IN, 0, 0, 0);
      outs(3'b001);
      rst_n = 1'b0;
      repeat (3) @(negedge clk);
    end
    conclude();
  end
endmodule : tb_io_and_homing_command_handler
`default_nettype wire
